// ==== pkg/ppr_defs.svh ====
`ifndef PPR_DEFS_SVH
`define PPR_DEFS_SVH

// Register indices; the byte address is four times the index
`define PPR_IDX_P3_LATCH    16'hf218
`define PPR_IDX_P3_DIR      16'hf219
`define PPR_IDX_P3_DRV_LO   16'hf21a
`define PPR_IDX_P3_DRV_HI   16'hf21b
`define PPR_IDX_P3_FSEL_LO  16'hf21c
`define PPR_IDX_P3_FSEL_HI  16'hf21d
`define PPR_IDX_P4_LATCH    16'hf220
`define PPR_IDX_P4_DIR      16'hf221
`define PPR_IDX_P4_DRV_LO   16'hf222
`define PPR_IDX_P4_DRV_HI   16'hf223
`define PPR_IDX_P4_FSEL_LO  16'hf224
`define PPR_IDX_P4_FSEL_HI  16'hf225

// Pin positions carrying the fifth PWM channel
`define PPR_P3_PWM_BIT      3'h5
`define PPR_P4_PWM_BIT      3'h7

// Port 3 implements bits 0..6 only
`define PPR_P3_MASK         8'h7f
`define PPR_RESET_BYTE      8'h00

// Function select code: high=1, low=0 selects tertiary
`define PPR_FUNC_TERTIARY   2'h2

`endif

// ==== pkg/ppr_pkg.sv ====
package ppr_pkg;

	// Per-port configuration bundle
	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] dir;
		logic [7:0] drv_lo;
		logic [7:0] drv_hi;
		logic [7:0] fsel_lo;
		logic [7:0] fsel_hi;
	} ppr_port_cfg_type;

	// Per-pin pad drive
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} ppr_pad_type;

	typedef enum logic [2:0] {
		PPR_IDLE   = 3'b001,
		PPR_SETUP  = 3'b010,
		PPR_ACCESS = 3'b100
	} ppr_apb_state_type;

endpackage

// ==== rtl/ppr_port_mux.sv ====
`timescale 1ns/1ps
`include "ppr_defs.svh"

module ppr_port_mux
	import ppr_pkg::*;
#(
	parameter int WIDTH   = 8,
	parameter int PWM_BIT = 5
) (
	input  wire ppr_port_cfg_type i_cfg,
	input  wire logic             i_pwm,
	output ppr_pad_type           o_pad,
	output logic [WIDTH-1:0]      o_pwm_mode
);

	// Each pin uses only its own bits; only PWM_BIT has a tertiary source
	always_comb begin
		o_pad      = '0;
		o_pwm_mode = '0;
		for (int i = 0; i < WIDTH; i++) begin
			if (i == PWM_BIT &&
			    {i_cfg.fsel_hi[i], i_cfg.fsel_lo[i]} == `PPR_FUNC_TERTIARY) begin
				o_pwm_mode[i] = 1'b1;
				// Latch bit deliberately unused here
				o_pad.out[i] = i_pwm;
				o_pad.oe[i]  = i_cfg.drv_hi[i] & i_cfg.drv_lo[i]
				               & ~i_cfg.dir[i];
			end else begin
				// Any non-tertiary function: drive latch when direction is output and drv_hi or drv_lo is set
				o_pad.out[i] = i_cfg.latch[i];
				o_pad.oe[i]  = ~i_cfg.dir[i] & (i_cfg.drv_hi[i] | i_cfg.drv_lo[i]);
			end
		end
	end

endmodule

// ==== rtl/ppr_pwm_channel_five_out_route.sv ====
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "ppr_defs.svh"

module ppr_pwm_channel_five_out_route
	import ppr_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_pwm_channel_five_out,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [7:0]  o_port3_out,
	output logic      [7:0]  o_port3_oe,
	output logic      [7:0]  o_port4_out,
	output logic      [7:0]  o_port4_oe,
	output logic             o_port3_pin5_pwm,
	output logic             o_port4_pin7_pwm
);

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	ppr_port_cfg_type p3;
	ppr_port_cfg_type p4;
	ppr_port_cfg_type next_p3;
	ppr_port_cfg_type next_p4;
	logic [31:0]      rdata;
	logic [31:0]      next_rdata;
	logic             hit;
	logic [7:0]       rd_byte;
	logic [7:0]       wbyte;
	logic             wr_en;

	function automatic logic [31:0] byte_addr(input logic [15:0] idx);
		byte_addr = {14'h0000, idx, 2'h0};
	endfunction

	assign wbyte = pwdata[7:0];
	// Single-cycle access phase; byte lane 0 holds the register
	assign wr_en = psel & penable & pwrite & pstrb[0];

	always_comb begin
		next_p3 = p3;
		next_p4 = p4;
		hit     = 1'b1;
		rd_byte = 8'h00;
		if (paddr == byte_addr(`PPR_IDX_P3_LATCH)) begin
			rd_byte = p3.latch;
			if (wr_en) next_p3.latch = wbyte & `PPR_P3_MASK;
		end else if (paddr == byte_addr(`PPR_IDX_P3_DIR)) begin
			rd_byte = p3.dir;
			if (wr_en) next_p3.dir = wbyte & `PPR_P3_MASK;
		end else if (paddr == byte_addr(`PPR_IDX_P3_DRV_LO)) begin
			rd_byte = p3.drv_lo;
			if (wr_en) next_p3.drv_lo = wbyte & `PPR_P3_MASK;
		end else if (paddr == byte_addr(`PPR_IDX_P3_DRV_HI)) begin
			rd_byte = p3.drv_hi;
			if (wr_en) next_p3.drv_hi = wbyte & `PPR_P3_MASK;
		end else if (paddr == byte_addr(`PPR_IDX_P3_FSEL_LO)) begin
			rd_byte = p3.fsel_lo;
			if (wr_en) next_p3.fsel_lo = wbyte & `PPR_P3_MASK;
		end else if (paddr == byte_addr(`PPR_IDX_P3_FSEL_HI)) begin
			rd_byte = p3.fsel_hi;
			if (wr_en) next_p3.fsel_hi = wbyte & `PPR_P3_MASK;
		end else if (paddr == byte_addr(`PPR_IDX_P4_LATCH)) begin
			rd_byte = p4.latch;
			if (wr_en) next_p4.latch = wbyte;
		end else if (paddr == byte_addr(`PPR_IDX_P4_DIR)) begin
			rd_byte = p4.dir;
			if (wr_en) next_p4.dir = wbyte;
		end else if (paddr == byte_addr(`PPR_IDX_P4_DRV_LO)) begin
			rd_byte = p4.drv_lo;
			if (wr_en) next_p4.drv_lo = wbyte;
		end else if (paddr == byte_addr(`PPR_IDX_P4_DRV_HI)) begin
			rd_byte = p4.drv_hi;
			if (wr_en) next_p4.drv_hi = wbyte;
		end else if (paddr == byte_addr(`PPR_IDX_P4_FSEL_LO)) begin
			rd_byte = p4.fsel_lo;
			if (wr_en) next_p4.fsel_lo = wbyte;
		end else if (paddr == byte_addr(`PPR_IDX_P4_FSEL_HI)) begin
			rd_byte = p4.fsel_hi;
			if (wr_en) next_p4.fsel_hi = wbyte;
		end else begin
			hit = 1'b0;
		end
		next_rdata = rdata;
		// Read data registered in setup so access phase presents it
		if (psel & ~penable & ~pwrite)
			next_rdata = {24'h000000, rd_byte};
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			p3    <= '0;
			p4    <= '0;
			rdata <= 32'h00000000;
		end else begin
			p3    <= next_p3;
			p4    <= next_p4;
			rdata <= next_rdata;
		end
	end

	assign prdata  = rdata;
	assign pready  = 1'b1;
	// Unmapped addresses answer with an error, writes are dropped
	assign pslverr = psel & penable & ~hit;

	// ---------------------------------------------------------------
	// Pin multiplexers
	// ---------------------------------------------------------------
	ppr_pad_type pad3;
	ppr_pad_type pad4;
	ppr_pad_type next_pad;
	ppr_pad_type next_pad4;
	logic [7:0]  mode3;
	logic [7:0]  mode4;
	ppr_pad_type q3;
	ppr_pad_type q4;
	logic        q3_mode;
	logic        q4_mode;

	ppr_port_mux #(
		.WIDTH   (8),
		.PWM_BIT (`PPR_P3_PWM_BIT)
	) u_port3 (
		.i_cfg      (p3),
		.i_pwm      (i_pwm_channel_five_out),
		.o_pad      (pad3),
		.o_pwm_mode (mode3)
	);

	ppr_port_mux #(
		.WIDTH   (8),
		.PWM_BIT (`PPR_P4_PWM_BIT)
	) u_port4 (
		.i_cfg      (p4),
		.i_pwm      (i_pwm_channel_five_out),
		.o_pad      (pad4),
		.o_pwm_mode (mode4)
	);

	always_comb begin
		next_pad  = pad3;
		next_pad4 = pad4;
		// Bit 7 of port 3 does not exist as a pin
		next_pad.out[7] = 1'b0;
		next_pad.oe[7]  = 1'b0;
	end

	// Registered pads: one cycle of latency, glitch-free outputs
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q3      <= '0;
			q4      <= '0;
			q3_mode <= 1'b0;
			q4_mode <= 1'b0;
		end else begin
			q3      <= next_pad;
			q4      <= next_pad4;
			q3_mode <= mode3[`PPR_P3_PWM_BIT];
			q4_mode <= mode4[`PPR_P4_PWM_BIT];
		end
	end

	assign o_port3_out      = q3.out;
	assign o_port3_oe       = q3.oe;
	assign o_port4_out      = q4.out;
	assign o_port4_oe       = q4.oe;
	assign o_port3_pin5_pwm = q3_mode;
	assign o_port4_pin7_pwm = q4_mode;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_p3_pwm_select: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(p3.fsel_hi[5] && !p3.fsel_lo[5]) |=> o_port3_pin5_pwm)
		else $error("port3 pin5 not in pwm mode");
	a_p3_cmos_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(p3.fsel_hi[5] && !p3.fsel_lo[5] && p3.drv_hi[5] && p3.drv_lo[5]
		 && !p3.dir[5]) |=> (o_port3_oe[5]
		 && o_port3_out[5] == $past(i_pwm_channel_five_out)))
		else $error("port3 pin5 not driving pwm");
	a_p3_latch_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(mode3[5] && p3.latch[5] != i_pwm_channel_five_out)
		|=> o_port3_out[5] != $past(p3.latch[5]))
		else $error("port3 pin5 followed latch");
	a_p4_pwm_select: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(p4.fsel_hi[7] && !p4.fsel_lo[7]) |=> o_port4_pin7_pwm)
		else $error("port4 pin7 not in pwm mode");
	a_p4_cmos_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(p4.fsel_hi[7] && !p4.fsel_lo[7] && p4.drv_hi[7] && p4.drv_lo[7]
		 && !p4.dir[7]) |=> (o_port4_oe[7]
		 && o_port4_out[7] == $past(i_pwm_channel_five_out)))
		else $error("port4 pin7 not driving pwm");
	a_p4_latch_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(mode4[7] && p4.latch[7] != i_pwm_channel_five_out)
		|=> o_port4_out[7] != $past(p4.latch[7]))
		else $error("port4 pin7 followed latch");
	a_p3_bit7_absent: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!p3.dir[7] && !p3.latch[7] && !p3.fsel_hi[7] && !o_port3_oe[7])
		else $error("port3 bit7 exists");
	a_other_pins_own: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!p3.dir[4] && p3.drv_lo[4] && !p3.fsel_hi[4])
		|=> (o_port3_out[4] == $past(p3.latch[4]) && o_port3_oe[4]))
		else $error("port3 pin4 disturbed");

endmodule

// ==== verif/ppr_pwm_channel_five_out_route_tb_top.sv ====
`timescale 1ns/1ps
`include "ppr_defs.svh"

module ppr_pwm_channel_five_out_route_tb_top;
	logic        i_sys_clk              = 1'b0;
	logic        i_rstn                 = 1'b0;
	logic        i_pwm_channel_five_out = 1'b0;
	logic        psel                   = 1'b0;
	logic        penable                = 1'b0;
	logic        pwrite                 = 1'b0;
	logic [31:0] paddr                  = 32'h0;
	logic [31:0] pwdata                 = 32'h0;
	logic [3:0]  pstrb                  = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  o_port3_out;
	logic [7:0]  o_port3_oe;
	logic [7:0]  o_port4_out;
	logic [7:0]  o_port4_oe;
	logic        o_port3_pin5_pwm;
	logic        o_port4_pin7_pwm;
	logic [31:0] rd;
	logic        err;
	int          num_errors = 0;
	int          n_tests    = 0;
	int          cycles     = 0;
	logic [15:0] offs [12]  = '{`PPR_IDX_P3_LATCH, `PPR_IDX_P3_DIR,
		`PPR_IDX_P3_DRV_LO, `PPR_IDX_P3_DRV_HI, `PPR_IDX_P3_FSEL_LO,
		`PPR_IDX_P3_FSEL_HI, `PPR_IDX_P4_LATCH, `PPR_IDX_P4_DIR,
		`PPR_IDX_P4_DRV_LO, `PPR_IDX_P4_DRV_HI, `PPR_IDX_P4_FSEL_LO,
		`PPR_IDX_P4_FSEL_HI};

	always #5 i_sys_clk = ~i_sys_clk;

	ppr_pwm_channel_five_out_route uut (
		.i_sys_clk              (i_sys_clk),
		.i_rstn                 (i_rstn),
		.i_pwm_channel_five_out (i_pwm_channel_five_out),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.paddr                  (paddr),
		.pwdata                 (pwdata),
		.pstrb                  (pstrb),
		.prdata                 (prdata),
		.pready                 (pready),
		.pslverr                (pslverr),
		.o_port3_out            (o_port3_out),
		.o_port3_oe             (o_port3_oe),
		.o_port4_out            (o_port4_out),
		.o_port4_oe             (o_port4_oe),
		.o_port3_pin5_pwm       (o_port3_pin5_pwm),
		.o_port4_pin7_pwm       (o_port4_pin7_pwm)
	);

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Registers sit at four times their printed offset
	task automatic apb(input logic w, input logic [15:0] off,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge i_sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {14'h0, off, 2'b00};
		pwdata  <= d;
		@(posedge i_sys_clk);
		penable <= 1'b1;
		do @(posedge i_sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] off, input logic [7:0] d);
		apb(1'b1, off, {24'h0, d}, rd, err);
	endtask

	// One pin setup: every pin driven, only the routed pin gets mode
	task automatic pins(input bit p4, input logic [7:0] lat,
		input logic [1:0] mode, input logic pwm);
		logic [7:0] m;
		logic [7:0] msk;
		logic [7:0] eo;
		int         base;
		m    = p4 ? 8'h80 : 8'h20;
		msk  = p4 ? 8'hff : `PPR_P3_MASK;
		base = p4 ? 6 : 0;
		wr(offs[base], lat);
		wr(offs[base+1], 8'h00);
		wr(offs[base+2], 8'hff);
		wr(offs[base+3], 8'hff);
		wr(offs[base+4], mode[0] ? m : 8'h00);
		wr(offs[base+5], mode[1] ? m : 8'h00);
		i_pwm_channel_five_out <= pwm;
		repeat (2) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		eo = (mode == `PPR_FUNC_TERTIARY) ?
			((lat & ~m) | (pwm ? m : 8'h00)) & msk : lat & msk;
		check("pad out", p4 ? o_port4_out : o_port3_out, eo);
		check("pad oe", p4 ? o_port4_oe : o_port3_oe, msk);
		check("pwm flag", p4 ? o_port4_pin7_pwm : o_port3_pin5_pwm,
			mode == `PPR_FUNC_TERTIARY);
		wr(offs[base+5], 8'h00);
	endtask

	// ------------------------------------------------------------
	// Hang guard
	// ------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			apb(1'b0, offs[i], 32'h0, rd, err);
			check("reset value", rd, 32'h0);
		end
		for (int i = 0; i < 12; i++) begin
			wr(offs[i], 8'hff);
			apb(1'b0, offs[i], 32'h0, rd, err);
			check("readback", rd, (i < 6) ? 32'h7f : 32'hff);
			check("mapped err", {31'h0, err}, 32'h0);
			check("pready", {31'h0, pready}, 32'h1);
			wr(offs[i], 8'h00);
		end
		// Hole between the two ports must refuse
		apb(1'b1, 16'hf21e, 32'hff, rd, err);
		check("unmapped wr err", {31'h0, err}, 32'h1);
		apb(1'b0, 16'hf21e, 32'h0, rd, err);
		check("unmapped rd", rd, 32'h0);
		for (int p = 0; p < 2; p++)
			for (int md = 0; md < 4; md++)
				for (int l = 0; l < 2; l++)
					for (int w = 0; w < 2; w++)
						pins(p[0], l ? 8'hff : 8'h5a, md[1:0], w[0]);
		stop_test();
	end
endmodule
